// ===== shared/mcib_regs.svh
// offsets, field codes and fixed values of the capability identification bytes
`ifndef MCIB_REGS_SVH
`define MCIB_REGS_SVH

// byte offsets on the upper identification page
`define MCIB_OFS_MODULE_TYPE_ID       8'h80
`define MCIB_OFS_MODULE_DESCRIPTION   8'h81
`define MCIB_OFS_REQUIRED_SUPPLIES    8'h82
`define MCIB_OFS_MAX_CASE_TEMPERATURE 8'h83
`define MCIB_OFS_MIN_SIGNAL_RATE      8'h84
`define MCIB_OFS_MAX_SIGNAL_RATE      8'h85
`define MCIB_OFS_CENTER_WAVELENGTH    8'h86
`define MCIB_OFS_WAVELENGTH_TOLERANCE 8'h88
`define MCIB_OFS_SUPPORTED_FLAGS      8'h8A
`define MCIB_OFS_SUPPORTED_MON_A      8'h8B
`define MCIB_OFS_SUPPORTED_MON_B      8'h8C
`define MCIB_OFS_CHECKSUM             8'hDF

// first and last byte held by this block, and the byte count
`define MCIB_CAP_FIRST                8'h80
`define MCIB_CAP_LAST                 8'h8C
`define MCIB_CAP_BYTES                13

// power class codes
`define MCIB_PWR_BELOW_1W5            2'h0
`define MCIB_PWR_BELOW_2W0            2'h1
`define MCIB_PWR_BELOW_2W5            2'h2
`define MCIB_PWR_BELOW_3W5            2'h3

// reserved bit groups and unmapped bytes read as zero
`define MCIB_RSVD1                    1'h0
`define MCIB_RSVD2                    2'h0
`define MCIB_RSVD3                    3'h0
`define MCIB_UNMAPPED                 8'h00

// serial engine constants
`define MCIB_BITS_PER_BYTE            4'h8
`define MCIB_BIT_STEP                 4'h1
`define MCIB_PTR_STEP                 8'h01
`define MCIB_DEV_ADDR_DEFAULT         7'h50
`define MCIB_DEV_ADDR_LIMIT           7'h78
`define MCIB_SDA_LOW                  1'h0

`endif

// ===== shared/mcib_pkg.sv
// types shared by the capability identification block
package mcib_pkg;

  // fixed capability contents, byte 128 field first
  typedef struct packed {
    logic [7:0]  module_type_id;
    logic [1:0]  power_class;
    logic        tx_clock_recovery;
    logic        rx_clock_recovery;
    logic        ref_clock_needed;
    logic        second_page_present;
    logic        controlled_launch;
    logic        supply_3v3;
    logic        supply_2v5;
    logic        supply_1v8;
    logic        auxiliary_supply;
    logic        variable_supply;
    logic [7:0]  max_case_temperature;
    logic [7:0]  min_signal_rate;
    logic [7:0]  max_signal_rate;
    logic [15:0] center_wavelength;
    logic [15:0] wavelength_tolerance;
    logic        tx_fault_flag;
    logic        tx_los_flag;
    logic        rx_los_flag;
    logic        cdr_lol_flag;
    logic        squelch_on_los;
    logic        alarm_and_warning;
    logic        tx_bias_monitor;
    logic        transmit_optical_power_monitor;
    logic        per_channel_rx_power;
    logic        rx_power_average;
    logic        case_temperature_monitor;
    logic        internal_temp_monitor;
    logic        peak_temp_monitor;
    logic        elapsed_time_monitor;
    logic        ber_monitor;
    logic        vcc_3v3_monitor;
    logic        vcc_2v5_monitor;
    logic        vcc_1v8_monitor;
    logic        auxiliary_supply_monitor;
    logic        thermoelectric_cooler_monitor;
  } mcib_cap_t;

  // serial engine states
  typedef enum logic [3:0] {
    MCIB_IDLE      = 4'b0000,
    MCIB_DEV       = 4'b0001,
    MCIB_DEV_ACK   = 4'b0010,
    MCIB_ADDR      = 4'b0011,
    MCIB_ADDR_ACK  = 4'b0100,
    MCIB_WDATA     = 4'b0101,
    MCIB_WDATA_ACK = 4'b0110,
    MCIB_RDATA     = 4'b0111,
    MCIB_RACK      = 4'b1000
  } mcib_state_t;

  // two-wire line levels after synchronising
  typedef struct packed {
    logic scl;
    logic sda;
  } mcib_line_t;

endpackage

// ===== core/mcib_pin_sync.sv
// two flip-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module mcib_pin_sync #(
  parameter int W = 2
) (
  // clock and reset
  input  wire logic         mclk,
  input  wire logic         resetn,
  // pins in, synchronised levels out
  input  wire logic [W-1:0] pin_level,
  output logic      [W-1:0] sync_level
);
  import mcib_pkg::*;

  typedef struct packed {
    logic [W-1:0] stage2;
    logic [W-1:0] stage1;
  } mcib_sync_t;

  mcib_sync_t r_q;
  mcib_sync_t r_d;

  if (W < 1) begin : g_bad_width
    $error("mcib_pin_sync needs at least one line");
  end

  // stage1 is read only by stage2
  always_comb begin
    r_d        = r_q;
    r_d.stage1 = pin_level;
    r_d.stage2 = r_q.stage1;
  end

  // idle two-wire lines are high, so reset to high
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      r_q <= '1;
    end else begin
      r_q <= r_d;
    end
  end

  assign sync_level = r_q.stage2;
endmodule

// ===== core/mcib_id_rom.sv
// fixed capability bytes and their check code, looked up by byte address
`timescale 1ns/1ps
`include "mcib_regs.svh"
module mcib_id_rom
  import mcib_pkg::*;
#(
  parameter mcib_pkg::mcib_cap_t CAP = '0
) (
  // byte lookup
  input  wire logic [7:0] byte_addr,
  output logic      [7:0] byte_data
);
  import mcib_pkg::*;

  localparam int NB = `MCIB_CAP_BYTES;

  // image of bytes 128..140, byte 128 in the top lane
  localparam logic [NB*8-1:0] IMG = {
    CAP.module_type_id,
    CAP.power_class, CAP.tx_clock_recovery, CAP.rx_clock_recovery,
    CAP.ref_clock_needed, CAP.second_page_present, CAP.controlled_launch,
    `MCIB_RSVD1,
    CAP.supply_3v3, CAP.supply_2v5, CAP.supply_1v8, CAP.auxiliary_supply,
    CAP.variable_supply, `MCIB_RSVD3,
    CAP.max_case_temperature,
    CAP.min_signal_rate,
    CAP.max_signal_rate,
    CAP.center_wavelength,
    CAP.wavelength_tolerance,
    CAP.tx_fault_flag, CAP.tx_los_flag, CAP.rx_los_flag, CAP.cdr_lol_flag,
    CAP.squelch_on_los, CAP.alarm_and_warning, `MCIB_RSVD2,
    CAP.tx_bias_monitor, CAP.transmit_optical_power_monitor,
    CAP.per_channel_rx_power, CAP.rx_power_average,
    CAP.case_temperature_monitor, CAP.internal_temp_monitor,
    CAP.peak_temp_monitor, CAP.elapsed_time_monitor,
    CAP.ber_monitor, CAP.vcc_3v3_monitor, CAP.vcc_2v5_monitor,
    CAP.vcc_1v8_monitor, CAP.auxiliary_supply_monitor,
    CAP.thermoelectric_cooler_monitor, `MCIB_RSVD2
  };

  // byte i of the image, counted from byte 128
  function automatic logic [7:0] img_byte(input int i);
    img_byte = IMG[(NB-1-i)*8 +: 8];
  endfunction

  // low eight bits of the sum; bytes 141..222 are zero in this block
  function automatic logic [7:0] img_sum();
    logic [7:0] s;
    s = '0;
    for (int i = 0; i < NB; i++) begin
      s = s + img_byte(i);
    end
    img_sum = s;
  endfunction

  localparam logic [7:0] CHECK_CODE = img_sum(); // R18

  // every value is a constant, so reads never depend on history
  always_comb begin
    if (byte_addr >= `MCIB_CAP_FIRST && byte_addr <= `MCIB_CAP_LAST) begin
      byte_data = img_byte(int'(byte_addr - `MCIB_CAP_FIRST));
    end else if (byte_addr == `MCIB_OFS_CHECKSUM) begin
      byte_data = CHECK_CODE; // R18
    end else begin
      byte_data = `MCIB_UNMAPPED;
    end
  end
endmodule

// ===== core/mcib_twowire_id.sv
// two-wire management slave serving the read-only capability identification bytes
`timescale 1ns/1ps
`include "mcib_regs.svh"

// Notes on behaviour
// R1 - byte 128 returns the module type identifier, 00h when unspecified
// R2 - byte 129 bits 7-6 give the power class code
// R3 - byte 129 bit 5 transmit, bit 4 receive clock recovery present
// R4 - byte 129 bit 3 set when an external reference clock is needed
// R5 - byte 129 bit 2 set when the second upper page exists
// R6 - byte 129 bit 1 controlled-launch transmitter; bit 0 reserved zero
// R7 - byte 130 flags required supplies in bits 7-3; bits 2-0 reserved
// R8 - byte 131 maximum case temperature, one degree per step
// R9 - byte 132 minimum channel rate in 100 Mb/s units, zero unknown
// R10 - byte 133 maximum channel rate in 100 Mb/s units, zero unknown
// R11 - bytes 134-135 centre wavelength, value over 20 in nm, zero unused
// R12 - bytes 136-137 wavelength tolerance, value over 200 in nm, zero unused
// R13 - byte 138 bits 7-3 flag supported indications; bits 1-0 reserved
// R14 - byte 138 bit 2 set for alarm and warning flags, clear alarms only
// R15 - byte 139 flags bias, power, temperature and elapsed time monitors
// R16 - byte 139 bit 5 per-channel receive power, bit 4 average power
// R17 - byte 140 flags error rate, supply and cooler monitors; bits 1-0 zero
// R18 - byte 223 holds low eight bits of sum of bytes 128..222
// R19 - host writes are ignored; every read returns the same fixed values
module mcib_twowire_id
  import mcib_pkg::*;
#(
  parameter logic [6:0]           DEV_ADDR = `MCIB_DEV_ADDR_DEFAULT,
  parameter mcib_pkg::mcib_cap_t  CAP      = '0
) (
  // clock and reset
  input  wire logic mclk,
  input  wire logic resetn,
  // two-wire management pins
  input  wire logic scl,
  input  wire logic sda_in,
  output logic      sda_out,
  output logic      sda_oe_n,
  // status
  output logic      busy
);
  import mcib_pkg::*;

  // all engine state in one record
  typedef struct packed {
    mcib_state_t state;
    logic [3:0]  bit_cnt;
    logic [7:0]  shreg;
    logic [7:0]  ptr;
    logic        rd_mode;
    logic        oe_n;
    mcib_line_t  line_prev;
  } mcib_core_t;

  mcib_core_t  r_q;
  mcib_core_t  r_d;
  mcib_line_t  line_s;
  logic [7:0]  rom_data;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_seen;
  logic        stop_seen;
  logic        byte_done;

  // refused at elaboration, before any logic is built
  if (DEV_ADDR >= `MCIB_DEV_ADDR_LIMIT) begin : g_bad_addr
    $error("mcib_twowire_id: device address falls in the reserved range");
  end
  if (CAP.power_class > `MCIB_PWR_BELOW_3W5) begin : g_bad_class
    $error("mcib_twowire_id: power class out of range");
  end

  // pins are asynchronous to mclk
  mcib_pin_sync #(
    .W (2)
  ) u_sync (
    .mclk       (mclk),
    .resetn     (resetn),
    .pin_level  ({scl, sda_in}),
    .sync_level (line_s)
  );

  // R1 R2 R3 R4 R5 R6 R7 R8 R9 R10 R11 R12 R13 R14 R15 R16 R17 R18
  mcib_id_rom #(
    .CAP (CAP)
  ) u_rom (
    .byte_addr (r_q.ptr),
    .byte_data (rom_data)
  );

  // edges and bus conditions, all on synchronised levels
  assign scl_rise   = line_s.scl && !r_q.line_prev.scl;
  assign scl_fall   = !line_s.scl && r_q.line_prev.scl;
  assign start_seen = line_s.scl && r_q.line_prev.scl &&
                      r_q.line_prev.sda && !line_s.sda;
  assign stop_seen  = line_s.scl && r_q.line_prev.scl &&
                      !r_q.line_prev.sda && line_s.sda;
  assign byte_done  = (r_q.bit_cnt == `MCIB_BITS_PER_BYTE);

  always_comb begin
    r_d           = r_q;
    r_d.line_prev = line_s;
    if (start_seen) begin
      // a repeated start is taken in any state, pointer kept
      r_d.state   = MCIB_DEV;
      r_d.bit_cnt = '0;
      r_d.oe_n    = 1'b1;
    end else if (stop_seen) begin
      r_d.state   = MCIB_IDLE;
      r_d.oe_n    = 1'b1;
    end else if (scl_rise) begin
      // sample host bits while clock is high
      if (r_q.state == MCIB_DEV || r_q.state == MCIB_ADDR ||
          r_q.state == MCIB_WDATA) begin
        r_d.shreg   = {r_q.shreg[6:0], line_s.sda};
        r_d.bit_cnt = r_q.bit_cnt + `MCIB_BIT_STEP;
      end else if (r_q.state == MCIB_RACK && line_s.sda) begin
        // host said no more: leave the line alone until next start
        r_d.state = MCIB_IDLE;
      end
    end else if (scl_fall) begin
      // the line only changes while clock is low
      unique case (r_q.state)
        MCIB_IDLE: begin
          r_d.oe_n = 1'b1;
        end
        MCIB_DEV: begin
          if (byte_done) begin
            if (r_q.shreg[7:1] == DEV_ADDR) begin
              r_d.rd_mode = r_q.shreg[0];
              r_d.oe_n    = 1'b0;
              r_d.state   = MCIB_DEV_ACK;
            end else begin
              // another device on the bus is addressed
              r_d.state   = MCIB_IDLE;
            end
          end
        end
        MCIB_DEV_ACK: begin
          if (r_q.rd_mode) begin
            // first bit of the byte at the pointer goes out now
            r_d.shreg   = {rom_data[6:0], 1'b0};
            r_d.oe_n    = rom_data[7];
            r_d.bit_cnt = `MCIB_BIT_STEP;
            r_d.state   = MCIB_RDATA;
          end else begin
            r_d.oe_n    = 1'b1;
            r_d.bit_cnt = '0;
            r_d.state   = MCIB_ADDR;
          end
        end
        MCIB_ADDR: begin
          if (byte_done) begin
            r_d.ptr   = r_q.shreg;
            r_d.oe_n  = 1'b0;
            r_d.state = MCIB_ADDR_ACK;
          end
        end
        MCIB_ADDR_ACK, MCIB_WDATA_ACK: begin
          r_d.oe_n    = 1'b1;
          r_d.bit_cnt = '0;
          r_d.state   = MCIB_WDATA;
        end
        MCIB_WDATA: begin
          if (byte_done) begin
            // acknowledged so the host sees no bus error, data dropped
            r_d.ptr   = r_q.ptr + `MCIB_PTR_STEP; // R19
            r_d.oe_n  = 1'b0;
            r_d.state = MCIB_WDATA_ACK;
          end
        end
        MCIB_RDATA: begin
          if (byte_done) begin
            r_d.oe_n  = 1'b1;
            r_d.ptr   = r_q.ptr + `MCIB_PTR_STEP;
            r_d.state = MCIB_RACK;
          end else begin
            r_d.oe_n    = r_q.shreg[7];
            r_d.shreg   = {r_q.shreg[6:0], 1'b0};
            r_d.bit_cnt = r_q.bit_cnt + `MCIB_BIT_STEP;
          end
        end
        MCIB_RACK: begin
          // host acknowledged: stream the next byte
          r_d.shreg   = {rom_data[6:0], 1'b0};
          r_d.oe_n    = rom_data[7];
          r_d.bit_cnt = `MCIB_BIT_STEP;
          r_d.state   = MCIB_RDATA;
        end
        default: begin
          r_d.state = MCIB_IDLE;
          r_d.oe_n  = 1'b1;
        end
      endcase
    end
  end

  // stored contents never change, so reset only restarts the engine
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      r_q.state     <= MCIB_IDLE;
      r_q.bit_cnt   <= '0;
      r_q.shreg     <= '0;
      r_q.ptr       <= '0;
      r_q.rd_mode   <= 1'b0;
      r_q.oe_n      <= 1'b1;
      r_q.line_prev <= '1;
    end else begin
      r_q <= r_d;
    end
  end

  // open drain: only ever pulls low
  assign sda_out  = `MCIB_SDA_LOW;
  assign sda_oe_n = r_q.oe_n; // R19
  assign busy     = (r_q.state != MCIB_IDLE);
endmodule

// ===== bench/mcib_twowire_id_asserts.sv
// pin-level protocol checks for the capability identification slave
`timescale 1ns/1ps
module mcib_twowire_id_asserts (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // two-wire pins and status
  input wire logic scl,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  input wire logic busy
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  sequence start_s;
    scl && $past(scl) && $fell(sda_in);
  endsequence
  sequence stop_s;
    scl && $past(scl) && $rose(sda_in);
  endsequence
  chk_out_low: assert property (sda_out == 1'h0)
    else $error("sda_out is not held low");
  chk_reset_quiet: assert property (!$past(resetn) |-> sda_oe_n && !busy)
    else $error("slave active just after reset");
  chk_idle_released: assert property (!busy |-> sda_oe_n)
    else $error("sda driven while idle");
  chk_start_busy: assert property (start_s |-> ##[1:6] busy)
    else $error("start not taken");
  chk_stop_idle: assert property (stop_s |-> ##[1:6] (!busy && sda_oe_n))
    else $error("stop did not return to idle");
  // the slave may only start pulling in the low phase, never right after scl falls
  chk_drive_low: assert property ($fell(sda_oe_n) |-> !scl && !$past(scl) && !$past(scl, 2))
    else $error("sda pulled outside scl low phase");
  chk_hold_high: assert property (scl && $past(scl) && busy |-> $stable(sda_oe_n))
    else $error("sda drive changed while scl high");
  chk_release_low: assert property ($rose(sda_oe_n) |-> !scl || !busy)
    else $error("sda released while scl high");
  cover property ($fell(sda_oe_n));
  cover property (start_s);
  cover property (stop_s);
endmodule

bind mcib_twowire_id mcib_twowire_id_asserts chk_u (
  .mclk(mclk), .resetn(resetn), .scl(scl), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe_n(sda_oe_n), .busy(busy)
);

// ===== bench/mcib_host_model.sv
// host management controller driving the two-wire pins, with pull-up on sda
`timescale 1ns/1ps
module mcib_host_model (
  // clock
  input  wire logic mclk,
  // two-wire pins
  input  wire logic sda_oe_n,
  output logic      scl,
  output logic      sda_in
);
  logic sda_drv;
  // wired-and with pull-up: a released line reads high
  assign sda_in = sda_drv & sda_oe_n;
  initial begin
    scl = 1'h1;
    sda_drv = 1'h1;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // phases of 4 mclk or more keep setup and hold around every scl edge
  task automatic put(input logic b, output logic r);
    scl <= 1'h0;
    hold(4);
    sda_drv <= b;
    hold(4);
    scl <= 1'h1;
    hold(6);
    r = sda_in;
  endtask
  task automatic start();
    scl <= 1'h0;
    hold(4);
    sda_drv <= 1'h1;
    hold(4);
    scl <= 1'h1;
    hold(6);
    sda_drv <= 1'h0;
    hold(6);
  endtask
  task automatic stop();
    scl <= 1'h0;
    hold(4);
    sda_drv <= 1'h0;
    hold(4);
    scl <= 1'h1;
    hold(6);
    sda_drv <= 1'h1;
    hold(6);
  endtask
  task automatic wbyte(input logic [7:0] v, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      put(v[i], r);
    end
    put(1'h1, r);
    ack = !r;
  endtask
  task automatic rbyte(input logic last, output logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      put(1'h1, v[i]);
    end
    put(last, r);
  endtask
endmodule

// ===== bench/tb.sv
// self-checking bench reading the capability bytes over the two-wire pins
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin err_total++; \
  $display("Error at %0t: got %h expected %h", $time, g, e); end end
module tb;
  import mcib_pkg::*;
  localparam logic [6:0] DEV = 7'h53;
  localparam mcib_cap_t CAP = 96'h5AB7_C91E_0A3C_2132_0F7D_B5A6;
  logic mclk;
  logic resetn;
  logic scl;
  logic sda_in;
  logic sda_out;
  logic sda_oe_n;
  logic busy;
  logic ack;
  logic [7:0] rd [0:13];
  logic [7:0] sum_v;
  int err_total;
  int check_count;
  mcib_twowire_id #(.DEV_ADDR(DEV), .CAP(CAP)) dut_u (
    .mclk(mclk), .resetn(resetn), .scl(scl), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .busy(busy)
  );
  mcib_host_model host_u (.mclk(mclk), .sda_oe_n(sda_oe_n), .scl(scl), .sda_in(sda_in));
  initial begin
    mclk = 1'h0;
    forever #20 mclk = ~mclk;
  end
  function automatic logic [7:0] exp_byte(input logic [7:0] a);
    case (a)
      8'h80: return CAP.module_type_id;
      8'h81: return {CAP.power_class, CAP.tx_clock_recovery, CAP.rx_clock_recovery,
        CAP.ref_clock_needed, CAP.second_page_present, CAP.controlled_launch, 1'h0};
      8'h82: return {CAP.supply_3v3, CAP.supply_2v5, CAP.supply_1v8,
        CAP.auxiliary_supply, CAP.variable_supply, 3'h0};
      8'h83: return CAP.max_case_temperature;
      8'h84: return CAP.min_signal_rate;
      8'h85: return CAP.max_signal_rate;
      8'h86: return CAP.center_wavelength[15:8];
      8'h87: return CAP.center_wavelength[7:0];
      8'h88: return CAP.wavelength_tolerance[15:8];
      8'h89: return CAP.wavelength_tolerance[7:0];
      8'h8A: return {CAP.tx_fault_flag, CAP.tx_los_flag, CAP.rx_los_flag,
        CAP.cdr_lol_flag, CAP.squelch_on_los, CAP.alarm_and_warning, 2'h0};
      8'h8B: return {CAP.tx_bias_monitor, CAP.transmit_optical_power_monitor,
        CAP.per_channel_rx_power, CAP.rx_power_average, CAP.case_temperature_monitor,
        CAP.internal_temp_monitor, CAP.peak_temp_monitor, CAP.elapsed_time_monitor};
      8'h8C: return {CAP.ber_monitor, CAP.vcc_3v3_monitor, CAP.vcc_2v5_monitor,
        CAP.vcc_1v8_monitor, CAP.auxiliary_supply_monitor,
        CAP.thermoelectric_cooler_monitor, 2'h0};
      default: return 8'h00;
    endcase
  endfunction
  task automatic set_ptr(input logic [7:0] p);
    host_u.start();
    host_u.wbyte({DEV, 1'h0}, ack);
    `CHK(ack, 1'h1);
    host_u.wbyte(p, ack);
    `CHK(ack, 1'h1);
  endtask
  task automatic read_seq(input logic [7:0] p, input int n);
    set_ptr(p);
    host_u.start();
    host_u.wbyte({DEV, 1'h1}, ack);
    `CHK(ack, 1'h1);
    for (int i = 0; i < n; i++) begin
      host_u.rbyte(i == n - 1, rd[i]);
    end
    host_u.stop();
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // a full run is near 4.7k mclk; the limit leaves ample room
  initial begin
    #2000000;
    err_total++;
    conclude();
  end
  initial begin
    resetn = 1'h0;
    err_total = 0;
    check_count = 0;
    repeat (5) @(posedge mclk);
    resetn <= 1'h1;
    repeat (4) @(posedge mclk);
    // one burst across every held byte and the first unheld one
    read_seq(8'h80, 14);
    `CHK(rd[0], exp_byte(8'h80));
    `CHK(rd[1], exp_byte(8'h81));
    `CHK(rd[2], exp_byte(8'h82));
    `CHK(rd[3], exp_byte(8'h83));
    `CHK(rd[4], exp_byte(8'h84));
    `CHK(rd[5], exp_byte(8'h85));
    `CHK({rd[6], rd[7]}, CAP.center_wavelength);
    `CHK({rd[8], rd[9]}, CAP.wavelength_tolerance);
    `CHK(rd[10], exp_byte(8'h8A));
    `CHK(rd[11], exp_byte(8'h8B));
    `CHK(rd[12], exp_byte(8'h8C));
    `CHK(rd[13], 8'h00);
    $display("test burst read done");
    // writes are taken on the wire but must not alter the contents
    set_ptr(8'h82);
    host_u.wbyte(8'hFF, ack);
    `CHK(ack, 1'h1);
    host_u.stop();
    read_seq(8'h82, 1);
    `CHK(rd[0], exp_byte(8'h82));
    host_u.start();
    host_u.wbyte({DEV ^ 7'h01, 1'h0}, ack);
    `CHK(ack, 1'h0);
    `CHK(busy, 1'h0);
    host_u.stop();
    $display("test write ignored done");
    // reset while the slave pulls the ack low must free the line, contents unchanged
    host_u.start();
    host_u.wbyte({DEV, 1'h1}, ack);
    resetn <= 1'h0;
    repeat (2) @(posedge mclk);
    `CHK(sda_oe_n, 1'h1);
    `CHK(busy, 1'h0);
    resetn <= 1'h1;
    repeat (4) @(posedge mclk);
    host_u.stop();
    read_seq(8'h80, 1);
    `CHK(rd[0], exp_byte(8'h80));
    $display("test reset in read done");
    read_seq(8'hDF, 1);
    sum_v = 8'h00;
    for (int a = 8'h80; a <= 8'hDE; a++) begin
      sum_v = sum_v + exp_byte(a[7:0]);
    end
    `CHK(rd[0], sum_v);
    $display("test check code done");
    conclude();
  end
endmodule
